// [hw/io_ctl_pkg.sv]
/*
 * Constants, port map and carrier types for the dedicated I/O control ports.
 * Assumes a 10 MHz system clock and a host I/O bus that gives one-cycle read
 * and write strobes on the same clock.
 */
// Behaviour
// - Index port write picks which configuration register the data port reaches.
// - Index port reads back the last value written.
// - Fast-gate read enables internal address gate, returns all ones; write disables.
// - Address line 20 passes if internal gate or keyboard controller gate enables.
// - Internal address gate is off after reset.
// - System control port bit 1 is the internal address gate.
// - Fast-gate port and system control bit 1 share one state.
// - Fast-gate port decoded only while special features are enabled.
// - Fast-reset port read starts a CPU reset and returns all ones.
// - CPU reset also follows the keyboard controller reset request.
// - Writing 1 to system control bit 0 resets CPU after delay, 16-cycle pulse.
// - System control reset bit holds until rewritten or device reset.
// - Fast-reset port off when features disabled; system control reset always works.
// - Slow port write enables slowing and modulation; fast port write disables slowing.
// - Fast port write stops modulation only while the full-speed pin is high.
// - A CPU clock change by a speed port issues a 1 ms CPU-only reset.
// - Speed ports decoded only while special features are enabled.
// - Speed port reads return undefined data and have no effect.
// - Unlock port permits, lock port blocks writes to E8h..EFh.
// - Lock feature inactive and lock port reads undefined when features disabled.
// - NMI control write with bit 7 low enables NMI from channel check or parity.
// - Each NMI source has its own enable bit in second control port.
// - Second control port bits 0..3 read/write, reset to 0; bits 4..7 read-only.
// - Bus control bit 7 low enables special feature decodes, high disables.
// - Channel gate low lets channel check low raise NMI; high ignores it.
// - Parity gate low lets parity errors raise NMI; high blocks them.
// - Writing 1 to the parity gate clears the parity error flag.
package io_ctl_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [9:0] SYSTEM_CTL_B = 10'h061;
  localparam logic [9:0] NMI_MASK_PORT = 10'h070;
  localparam logic [9:0] PS2_SYSTEM_CTL_A = 10'h092;
  localparam logic [9:0] LOCK_RANGE_LO = 10'h0E8;
  localparam logic [9:0] LOCK_RANGE_HI = 10'h0EF;
  localparam logic [9:0] CONFIG_INDEX = 10'h0EC;
  localparam logic [9:0] CONFIG_DATA_WINDOW = 10'h0ED;
  localparam logic [9:0] FAST_GATE_A20 = 10'h0EE;
  localparam logic [9:0] FAST_CPU_RESTART = 10'h0EF;
  localparam logic [9:0] SLOW_SPEED_TRIGGER = 10'h0F4;
  localparam logic [9:0] FULL_SPEED_TRIGGER = 10'h0F5;
  localparam logic [9:0] CONFIG_LOCK = 10'h0F9;
  localparam logic [9:0] CONFIG_UNLOCK = 10'h0FB;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int BUS_CONTROL_REG_VSF_BIT = 7;
  localparam int NMI_MASK_BIT = 7;
  localparam int CTL_A_RESET_BIT = 0;
  localparam int CTL_A_GATE_BIT = 1;
  localparam int CTL_B_TIMER_GATE_BIT = 0;
  localparam int CTL_B_SPEAKER_BIT = 1;
  localparam int CTL_B_PARITY_GATE_BIT = 2;
  localparam int CTL_B_CHANNEL_GATE_BIT = 3;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [5:0] CTL_A_FILL = 6'h3F;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [3:0] CTL_B_RESET = 4'h0;
  localparam logic UNLOCKED_RESET = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_DELAY_NS = 6720;
  localparam int RESET_DELAY_CYCLES = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYCLES = 16;
  localparam int SPEED_RESET_US = 1;
  localparam int SPEED_RESET_MS = 1;
  localparam int SPEED_RESET_CYCLES_DEF = (SPEED_RESET_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TIMER_W = 14;

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic kbc_gate_a20;
    logic kbc_reset_request_n;
    logic full_speed_pin;
    logic channel_check_in_n;
    logic parity_error_in;
  } pins_t;

  localparam pins_t PINS_IDLE = '{kbc_gate_a20: 1'b0, kbc_reset_request_n: 1'b1,
    full_speed_pin: 1'b0, channel_check_in_n: 1'b1, parity_error_in: 1'b0};

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_PULSE, ST_SPEED} reset_state_t;

endpackage : io_ctl_pkg

// [hw/io_ctl_ports.sv]
/*
 * Dedicated I/O control ports: configuration index/data pair, fast address
 * gate and fast CPU reset, speed triggers, configuration lock, NMI gating.
 * Assumes the host strobes rd or wr for one clk_sys cycle and that cfg_rdata
 * follows cfg_index combinationally from the configuration register file.
 */
module io_ctl_ports
  import io_ctl_pkg::*;
#(
  parameter int SPEED_RESET_CYCLES = SPEED_RESET_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire io_req_t io_req,
  output logic io_hit,
  output logic [7:0] io_rdata,
  output logic io_rdata_valid,
  input wire logic [7:0] bus_control_reg,
  output logic [7:0] cfg_index,
  output logic [7:0] cfg_wdata,
  output logic cfg_wr,
  output logic cfg_rd,
  input wire logic [7:0] cfg_rdata,
  input wire pins_t pins,
  input wire logic timer2_out,
  input wire logic refresh_toggle,
  output logic a20_out,
  output logic cpu_reset,
  output logic cpu_clock_slow,
  output logic snoop_modulate_en,
  output logic timer2_gate,
  output logic speaker_data,
  output logic nmi
);

  // Refused at elaboration: the timer cannot count it
  // Longer speed resets need a wider timer
  if (SPEED_RESET_CYCLES < 1 || SPEED_RESET_CYCLES >= (1 << TIMER_W)) begin : g_speed_range
    $error("SPEED_RESET_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  pins_t pin_meta;
  pins_t pin_sync;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_meta <= PINS_IDLE;
      pin_sync <= PINS_IDLE;
    end else begin
      pin_meta <= pins;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic logic hit(input logic [9:0] a, input logic [9:0] port);
    return a == port;
  endfunction : hit

  logic special_features_disable_n;
  logic unlocked;
  logic write_ok;
  logic rd;
  logic wr;

  // Bit high means the feature decodes are off
  assign special_features_disable_n = bus_control_reg[BUS_CONTROL_REG_VSF_BIT];
  assign rd = io_req.rd;
  assign wr = io_req.wr;
  // Lock only bites while the features are enabled
  assign write_ok = !(io_req.addr >= LOCK_RANGE_LO && io_req.addr <= LOCK_RANGE_HI)
    || unlocked || special_features_disable_n;

  logic dec_idx;
  logic dec_data;
  logic dec_gate;
  logic dec_fast_rst;
  logic dec_slow;
  logic dec_full;
  logic dec_lock;
  logic dec_unlock;
  logic dec_ctl_a;
  logic dec_ctl_b;
  logic dec_nmi;

  always_comb begin
    dec_idx = hit(io_req.addr, CONFIG_INDEX);
    dec_data = hit(io_req.addr, CONFIG_DATA_WINDOW);
    dec_gate = hit(io_req.addr, FAST_GATE_A20) && !special_features_disable_n;
    dec_fast_rst = hit(io_req.addr, FAST_CPU_RESTART) && !special_features_disable_n;
    dec_slow = hit(io_req.addr, SLOW_SPEED_TRIGGER) && !special_features_disable_n;
    dec_full = hit(io_req.addr, FULL_SPEED_TRIGGER) && !special_features_disable_n;
    dec_lock = hit(io_req.addr, CONFIG_LOCK) && !special_features_disable_n;
    dec_unlock = hit(io_req.addr, CONFIG_UNLOCK) && !special_features_disable_n;
    dec_ctl_a = hit(io_req.addr, PS2_SYSTEM_CTL_A);
    dec_ctl_b = hit(io_req.addr, SYSTEM_CTL_B);
    dec_nmi = hit(io_req.addr, NMI_MASK_PORT);
  end

  assign io_hit = dec_idx || dec_data || dec_gate || dec_fast_rst || dec_slow || dec_full
    || dec_lock || dec_unlock || dec_ctl_a || dec_ctl_b || dec_nmi;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration index and data window
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_index <= INDEX_RESET;
    end else if (wr && dec_idx && write_ok) begin
      cfg_index <= io_req.wdata;
    end
  end

  assign cfg_wr = wr && dec_data && write_ok;
  assign cfg_rd = rd && dec_data;
  assign cfg_wdata = io_req.wdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration lock
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      unlocked <= UNLOCKED_RESET;
    end else if (wr && dec_unlock) begin
      unlocked <= 1'b1;
    end else if (wr && dec_lock) begin
      unlocked <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address line 20 gate, shared by fast-gate port and control bit 1
  logic int_gate;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      int_gate <= 1'b0;
    end else if (rd && dec_gate) begin
      int_gate <= 1'b1;
    end else if (wr && dec_gate && write_ok) begin
      int_gate <= 1'b0;
    end else if (wr && dec_ctl_a) begin
      int_gate <= io_req.wdata[CTL_A_GATE_BIT];
    end
  end

  assign a20_out = int_gate || pin_sync.kbc_gate_a20;

  ////////////////////////////////////////////////////////////////////////////////
  // Speed control
  logic full_write;
  logic slow_write;
  logic speed_change;

  assign slow_write = wr && dec_slow;
  assign full_write = wr && dec_full;
  assign speed_change = (slow_write && !cpu_clock_slow) || (full_write && cpu_clock_slow);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cpu_clock_slow <= 1'b0;
    end else if (slow_write) begin
      cpu_clock_slow <= 1'b1;
    end else if (full_write) begin
      cpu_clock_slow <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      snoop_modulate_en <= 1'b0;
    end else if (slow_write) begin
      snoop_modulate_en <= 1'b1;
    end else if (full_write && pin_sync.full_speed_pin) begin
      snoop_modulate_en <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // CPU reset sequencer
  logic reset_latch;
  logic fast_trigger;
  reset_state_t state;
  logic [TIMER_W-1:0] timer;
  logic cpu_pulse;

  // Only a 0 to 1 step of the latch starts a port A reset; rewriting 1 does not repeat it
  assign fast_trigger = (rd && dec_fast_rst)
    || (wr && dec_ctl_a && io_req.wdata[CTL_A_RESET_BIT] && !reset_latch);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reset_latch <= 1'b0;
    end else if (wr && dec_ctl_a) begin
      reset_latch <= io_req.wdata[CTL_A_RESET_BIT];
    end
  end

  // A speed reset in progress is not cut short by a fast reset request
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      timer <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (speed_change) begin
            state <= ST_SPEED;
            timer <= TIMER_W'(SPEED_RESET_CYCLES - 1);
          end else if (fast_trigger) begin
            state <= ST_DELAY;
            timer <= TIMER_W'(RESET_DELAY_CYCLES - 1);
          end
        end
        ST_DELAY: begin
          if (timer == '0) begin
            state <= ST_PULSE;
            timer <= TIMER_W'(RESET_PULSE_CYCLES - 1);
          end else begin
            timer <= timer - 1'b1;
          end
        end
        ST_PULSE, ST_SPEED: begin
          if (timer == '0) begin
            state <= ST_IDLE;
          end else begin
            timer <= timer - 1'b1;
          end
        end
      endcase
    end
  end

  assign cpu_pulse = state == ST_PULSE;
  assign cpu_reset = cpu_pulse || state == ST_SPEED || !pin_sync.kbc_reset_request_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Second control port and NMI
  logic [3:0] ctl_b;
  logic parity_error_flag;
  logic channel_error_flag;
  logic nmi_enabled;
  logic channel_nmi_gate;
  logic parity_nmi_gate;

  assign parity_nmi_gate = ctl_b[CTL_B_PARITY_GATE_BIT];
  assign channel_nmi_gate = ctl_b[CTL_B_CHANNEL_GATE_BIT];
  assign timer2_gate = ctl_b[CTL_B_TIMER_GATE_BIT];
  assign speaker_data = ctl_b[CTL_B_SPEAKER_BIT];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctl_b <= CTL_B_RESET;
    end else if (wr && dec_ctl_b) begin
      ctl_b <= io_req.wdata[3:0];
    end
  end

  // Set wins over the clearing write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      parity_error_flag <= 1'b0;
    end else if (pin_sync.parity_error_in && !parity_nmi_gate) begin
      parity_error_flag <= 1'b1;
    end else if (wr && dec_ctl_b && io_req.wdata[CTL_B_PARITY_GATE_BIT]) begin
      parity_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      channel_error_flag <= 1'b0;
    end else if (!pin_sync.channel_check_in_n && !channel_nmi_gate) begin
      channel_error_flag <= 1'b1;
    end else if (wr && dec_ctl_b && io_req.wdata[CTL_B_CHANNEL_GATE_BIT]) begin
      channel_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      nmi_enabled <= 1'b0;
    end else if (wr && dec_nmi) begin
      nmi_enabled <= !io_req.wdata[NMI_MASK_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      nmi <= 1'b0;
    end else begin
      nmi <= nmi_enabled && ((parity_error_flag && !parity_nmi_gate)
        || (channel_error_flag && !channel_nmi_gate));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = ALL_ONES;
    if (dec_idx) begin
      next_rdata = cfg_index;
    end else if (dec_data) begin
      next_rdata = cfg_rdata;
    end else if (dec_ctl_a) begin
      next_rdata = {CTL_A_FILL, int_gate, reset_latch};
    end else if (dec_ctl_b) begin
      next_rdata = {parity_error_flag, channel_error_flag, timer2_out, refresh_toggle, ctl_b};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      io_rdata <= ALL_ONES;
      io_rdata_valid <= 1'b0;
    end else begin
      io_rdata_valid <= rd;
      if (rd) begin
        io_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  AST_GATE_READ: assert property (rd && dec_gate |=> int_gate && io_rdata == ALL_ONES)
    else $error("fast-gate read did not enable gate");
  AST_GATE_WRITE: assert property (wr && dec_gate && write_ok |=> !int_gate)
    else $error("fast-gate write did not disable gate");
  AST_A20_OR: assert property (pin_sync.kbc_gate_a20 || int_gate |-> a20_out)
    else $error("address gate not passed");
  AST_GATE_DECODE: assert property (special_features_disable_n && !dec_ctl_a |=> $stable(int_gate))
    else $error("fast-gate decoded while disabled");
  AST_RESET_TIMING: assert property (fast_trigger && state == ST_IDLE && !speed_change
    |-> ##68 !cpu_pulse ##1 cpu_pulse ##15 cpu_pulse ##1 !cpu_pulse)
    else $error("fast reset timing wrong");
  AST_SPEED_RESET: assert property (speed_change && state == ST_IDLE |=> state == ST_SPEED && cpu_reset)
    else $error("speed change gave no reset");
  AST_MOD_HOLD: assert property (full_write && !pin_sync.full_speed_pin && !slow_write
    |=> snoop_modulate_en == $past(snoop_modulate_en))
    else $error("modulation cancelled without full-speed pin");
  AST_LOCKED: assert property (!unlocked && !special_features_disable_n && wr && dec_idx |=> $stable(cfg_index))
    else $error("index written while locked");
  AST_NMI_CAUSE: assert property (nmi |-> $past(nmi_enabled)
    && ($past(parity_error_flag) || $past(channel_error_flag)))
    else $error("NMI without enabled cause");
  AST_PARITY_BLOCK: assert property (parity_nmi_gate && !parity_error_flag |=> !parity_error_flag)
    else $error("parity flag set while blocked");

  COV_FAST_RESET: cover property (fast_trigger ##69 cpu_pulse);
  COV_SPEED: cover property (slow_write ##1 state == ST_SPEED);
  COV_NMI: cover property (nmi_enabled && channel_error_flag ##1 nmi);
  COV_LOCKED_WRITE: cover property (!unlocked && wr && dec_idx);

endmodule : io_ctl_ports

// [tb/host_io_model.sv]
/*
 * Host CPU side of the I/O bus: one-cycle read and write strobes.
 * Assumes every task is entered just after a clk_sys rising edge.
 */
module host_io_model
  import io_ctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] io_rdata,
  input wire logic io_rdata_valid,
  output io_req_t io_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial io_req = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // A spare edge before each strobe, so back-to-back calls never retoggle in one step
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #10;
    io_req.addr = a;
    io_req.wdata = d;
    io_req.wr = 1'b1;
    @(posedge clk_sys);
    #10;
    io_req.wr = 1'b0;
    io_req.wdata = ~d;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    #10;
    io_req.addr = a;
    io_req.rd = 1'b1;
    @(posedge clk_sys);
    #10;
    io_req.rd = 1'b0;
    d = io_rdata;
    v = io_rdata_valid;
  endtask : rd
endmodule : host_io_model

// [tb/tb_top.sv]
/*
 * Self-checking bench for the dedicated I/O control ports.
 * Assumes the host model above and a small configuration register file here.
 */
module tb_top;
  import io_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // Short speed reset keeps the run brief
  localparam int SPD = 20;
  // Reset rises on the edge that ends the delay count
  localparam int FAST_RISE = RESET_DELAY_CYCLES;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  io_req_t io_req;
  logic io_hit, io_rdata_valid, cfg_wr, cfg_rd, a20_out, cpu_reset, cpu_clock_slow;
  logic snoop_modulate_en, timer2_gate, speaker_data, nmi;
  logic [7:0] io_rdata, cfg_index, cfg_wdata, cfg_rdata;
  logic [7:0] bus_control_reg = 8'h00;
  logic [7:0] cfg_mem [256];
  pins_t pins = PINS_IDLE;
  int n_fail = 0;
  int cmp_count = 0;
  int cfg_rd_count = 0;
  // Distinct levels so the read-only bits show their order
  logic timer2_out = 1'b1;
  logic refresh_toggle = 1'b0;
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  host_io_model u_host (.clk_sys(clk_sys), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
    .io_req(io_req));
  io_ctl_ports #(.SPEED_RESET_CYCLES(SPD)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .io_req(io_req),
    .io_hit(io_hit), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid), .bus_control_reg(bus_control_reg),
    .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .pins(pins), .timer2_out(timer2_out), .refresh_toggle(refresh_toggle), .a20_out(a20_out), .cpu_reset(cpu_reset),
    .cpu_clock_slow(cpu_clock_slow), .snoop_modulate_en(snoop_modulate_en), .timer2_gate(timer2_gate),
    .speaker_data(speaker_data), .nmi(nmi));
  // Config register file stands in for the indexed registers
  always_ff @(posedge clk_sys) begin
    if (cfg_wr) begin
      cfg_mem[cfg_index] <= cfg_wdata;
    end
  end
  assign cfg_rdata = cfg_mem[cfg_index];
  always_ff @(posedge clk_sys) begin
    if (cfg_rd) begin
      cfg_rd_count <= cfg_rd_count + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdm(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    logic [7:0] d;
    logic v;
    u_host.rd(a, d, v);
    chk({nm, " valid"}, 8'h01, {7'h00, v});
    chk(nm, e, d & m);
  endtask : rdm
  task automatic cycles(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #10;
    end
  endtask : cycles
  // Bounded wait for cpu_reset to rise, then its high time
  task automatic measure(input int e_rise, input int e_width);
    int rise;
    int width;
    rise = 0;
    width = 0;
    while (cpu_reset !== 1'b1 && rise < 2000) begin
      cycles(1);
      rise++;
    end
    while (cpu_reset === 1'b1 && width < 2000) begin
      cycles(1);
      width++;
    end
    if (rise >= 2000 || width >= 2000) begin
      n_fail++;
      $display("MISMATCH cpu_reset pulse expected %0d seen none", e_rise);
      wrap_up();
    end else begin
      chk("reset delay", e_rise[7:0], rise[7:0]);
      chk("reset width", e_width[7:0], width[7:0]);
    end
  endtask : measure
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_after_reset;
    chk("a20 reset", 8'h00, {7'h00, a20_out});
    chk("index reset", INDEX_RESET, cfg_index);
    chk("nmi reset", 8'h00, {7'h00, nmi});
    rdm(SYSTEM_CTL_B, 8'hFF, {4'h2, CTL_B_RESET}, "ctl_b reset");
  endtask : t_after_reset
  task automatic t_index;
    u_host.wr(CONFIG_INDEX, 8'h5A);
    rdm(CONFIG_INDEX, 8'hFF, 8'h5A, "index readback");
    chk("index hit", 8'h01, {7'h00, io_hit});
    u_host.wr(CONFIG_DATA_WINDOW, 8'hC3);
    u_host.wr(CONFIG_INDEX, 8'h3C);
    u_host.wr(CONFIG_DATA_WINDOW, 8'h99);
    rdm(CONFIG_DATA_WINDOW, 8'hFF, 8'h99, "data at 3C");
    u_host.wr(CONFIG_INDEX, 8'h5A);
    rdm(CONFIG_DATA_WINDOW, 8'hFF, 8'hC3, "data at 5A");
    chk("data read strobes", 8'h02, cfg_rd_count[7:0]);
  endtask : t_index
  task automatic t_gate;
    rdm(FAST_GATE_A20, 8'hFF, ALL_ONES, "gate read");
    chk("a20 on", 8'h01, {7'h00, a20_out});
    rdm(PS2_SYSTEM_CTL_A, 8'h02, 8'h02, "ctl_a gate");
    u_host.wr(FAST_GATE_A20, 8'h5A);
    chk("a20 off", 8'h00, {7'h00, a20_out});
    pins.kbc_gate_a20 = 1'b1;
    cycles(3);
    chk("a20 kbc", 8'h01, {7'h00, a20_out});
    pins.kbc_gate_a20 = 1'b0;
    cycles(3);
    u_host.wr(PS2_SYSTEM_CTL_A, 8'h02);
    chk("a20 ctl_a", 8'h01, {7'h00, a20_out});
    u_host.wr(PS2_SYSTEM_CTL_A, 8'h00);
    chk("a20 ctl_a off", 8'h00, {7'h00, a20_out});
  endtask : t_gate
  task automatic t_lock;
    u_host.wr(CONFIG_LOCK, 8'h00);
    u_host.wr(CONFIG_INDEX, 8'h11);
    rdm(CONFIG_INDEX, 8'hFF, 8'h5A, "locked index");
    u_host.wr(CONFIG_UNLOCK, 8'h00);
    u_host.wr(CONFIG_INDEX, 8'h11);
    rdm(CONFIG_INDEX, 8'hFF, 8'h11, "unlocked index");
    // Locked first, so only the disable bit can let the write through
    u_host.wr(CONFIG_LOCK, 8'h00);
    bus_control_reg = 8'h80;
    u_host.wr(CONFIG_INDEX, 8'h22);
    rdm(CONFIG_INDEX, 8'hFF, 8'h22, "lock off index");
    u_host.wr(CONFIG_UNLOCK, 8'h00);
    bus_control_reg = 8'h00;
    u_host.wr(CONFIG_INDEX, 8'h33);
    rdm(CONFIG_INDEX, 8'hFF, 8'h22, "unlock dead index");
    bus_control_reg = 8'h80;
  endtask : t_lock
  // Features disabled: special ports dead, port A reset still live
  task automatic t_disabled;
    rdm(FAST_GATE_A20, 8'hFF, 8'hFF, "gate dead read");
    chk("gate dead hit", 8'h00, {7'h00, io_hit});
    chk("a20 dead", 8'h00, {7'h00, a20_out});
    u_host.wr(SLOW_SPEED_TRIGGER, 8'h00);
    chk("slow dead", 8'h00, {7'h00, cpu_clock_slow});
    rdm(FAST_CPU_RESTART, 8'hFF, 8'hFF, "restart dead read");
    // Lands inside the pulse that a live decode would give
    cycles(RESET_DELAY_CYCLES + 2);
    chk("restart dead", 8'h00, {7'h00, cpu_reset});
    u_host.wr(PS2_SYSTEM_CTL_A, 8'h01);
    measure(FAST_RISE, RESET_PULSE_CYCLES);
    rdm(PS2_SYSTEM_CTL_A, 8'h01, 8'h01, "reset latch");
    bus_control_reg = 8'h00;
    u_host.wr(CONFIG_UNLOCK, 8'h00);
  endtask : t_disabled
  task automatic t_restart;
    u_host.wr(PS2_SYSTEM_CTL_A, 8'h00);
    rdm(FAST_CPU_RESTART, 8'hFF, ALL_ONES, "restart read");
    measure(FAST_RISE, RESET_PULSE_CYCLES);
    pins.kbc_reset_request_n = 1'b0;
    cycles(3);
    chk("kbc reset", 8'h01, {7'h00, cpu_reset});
    pins.kbc_reset_request_n = 1'b1;
    cycles(3);
  endtask : t_restart
  // Speed reset starts on the strobe edge itself
  task automatic t_speed;
    u_host.wr(SLOW_SPEED_TRIGGER, 8'h00);
    chk("slow on", 8'h01, {7'h00, cpu_clock_slow});
    chk("modulate on", 8'h01, {7'h00, snoop_modulate_en});
    measure(0, SPD);
    u_host.wr(SLOW_SPEED_TRIGGER, 8'h00);
    chk("no change no reset", 8'h00, {7'h00, cpu_reset});
    rdm(SLOW_SPEED_TRIGGER, 8'h00, 8'h00, "slow read");
    chk("slow read no effect", 8'h01, {7'h00, cpu_clock_slow});
    chk("slow read no reset", 8'h00, {7'h00, cpu_reset});
    u_host.wr(FULL_SPEED_TRIGGER, 8'h00);
    chk("slow off", 8'h00, {7'h00, cpu_clock_slow});
    chk("modulate kept", 8'h01, {7'h00, snoop_modulate_en});
    measure(0, SPD);
    pins.full_speed_pin = 1'b1;
    u_host.wr(SLOW_SPEED_TRIGGER, 8'h00);
    measure(0, SPD);
    u_host.wr(FULL_SPEED_TRIGGER, 8'h00);
    chk("modulate off", 8'h00, {7'h00, snoop_modulate_en});
    measure(0, SPD);
  endtask : t_speed
  task automatic t_nmi;
    u_host.wr(SYSTEM_CTL_B, 8'h00);
    u_host.wr(NMI_MASK_PORT, 8'h00);
    pins.channel_check_in_n = 1'b0;
    cycles(5);
    chk("nmi channel", 8'h01, {7'h00, nmi});
    u_host.wr(SYSTEM_CTL_B, 8'h08);
    cycles(5);
    chk("nmi channel gated", 8'h00, {7'h00, nmi});
    u_host.wr(SYSTEM_CTL_B, 8'h00);
    cycles(5);
    u_host.wr(NMI_MASK_PORT, 8'h80);
    cycles(2);
    chk("nmi masked", 8'h00, {7'h00, nmi});
    pins.channel_check_in_n = 1'b1;
    // Pin must be idle inside first, or the set beats the clear
    cycles(3);
    u_host.wr(SYSTEM_CTL_B, 8'h08);
    u_host.wr(NMI_MASK_PORT, 8'h00);
    pins.parity_error_in = 1'b1;
    cycles(5);
    chk("nmi parity", 8'h01, {7'h00, nmi});
    pins.parity_error_in = 1'b0;
    cycles(3);
    u_host.wr(SYSTEM_CTL_B, 8'hFC);
    cycles(3);
    chk("parity cleared", 8'h00, {7'h00, nmi});
    rdm(SYSTEM_CTL_B, 8'hFF, 8'h2C, "ctl_b rw");
    u_host.wr(SYSTEM_CTL_B, 8'h03);
    chk("timer2 gate", 8'h01, {7'h00, timer2_gate});
    chk("speaker data", 8'h01, {7'h00, speaker_data});
  endtask : t_nmi
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cycles(10);
    sys_rst = 1'b0;
    t_after_reset();
    t_index();
    t_gate();
    t_lock();
    t_disabled();
    t_restart();
    t_speed();
    t_nmi();
    wrap_up();
  end
endmodule : tb_top
